// ### rtl/supply_supervisor_control.v
// supply supervisor control registers behind a classic wishbone slave
//
// Chosen here: the Wishbone register port.
`include "supply_supervisor_defines.vh"

module supply_supervisor_control (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [9:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output wire        ack_o,
  // analog side
  input  wire        supply_below_detect_i,
  output wire [3:0]  reset_threshold_select_o,
  output wire [3:0]  detect_threshold_select_o,
  output wire        detect_enable_o,
  output wire        detect_interrupt_flag_o,
  output wire        low_voltage_reset_disable_o,
  output wire        power_on_reset_disable_o
);

  // register state; the three fields live in loadable field registers
  wire [3:0]  reset_sel_q;
  wire [3:0]  detect_sel_q;
  wire [7:0]  pd_option_q;
  reg         flag_q;
  reg         flag_d;
  reg         ack_q;
  reg         ack_d;
  reg  [31:0] rdata_d;
  reg         lowv_reset_off;
  reg         power_on_off;

  wire       req      = cyc_i & stb_i & ~ack_q;
  wire [7:0] idx      = adr_i[9:2];
  wire       wr_lane0 = req & we_i & sel_i[0];
  wire       hit_rst  = (idx == `RESET_CTRL_IDX);
  wire       hit_det  = (idx == `DETECT_CTRL_IDX);
  wire       hit_pd   = (idx == `POWER_DOWN_IDX);
  // detection is gated by the select code itself
  wire       det_en   = (detect_sel_q != `DETECT_OFF_CODE);
  wire       det_evt  = det_en & supply_below_detect_i;
  wire       flag_clr = wr_lane0 & hit_rst & ~dat_i[`FLAG_BIT];

  // one write strobe per register, all on the low byte lane
  wire       wr_rst   = wr_lane0 & hit_rst;
  wire       wr_det   = wr_lane0 & hit_det;
  wire       wr_pd    = wr_lane0 & hit_pd;
  wire       rd_req   = req & ~we_i;

  // single-cycle answer: ack one edge after the request, dropped the next
  always @* begin
    ack_d = req;
  end

  // registered so the answer never depends on this cycle's address decode
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end
  assign ack_o = ack_q;

  // reset threshold select, read/write, cleared by reset
  supervisor_field_reg #(
    .WIDTH       (4),
    .RESET_VALUE (`THRESH_RST)
  ) reset_sel_reg (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (wr_rst),
    .data_i  (dat_i[`THRESH_MSB:`THRESH_LSB]),
    .value_o (reset_sel_q)
  );

  // detect threshold select; code zero keeps detection off
  supervisor_field_reg #(
    .WIDTH       (4),
    .RESET_VALUE (`THRESH_RST)
  ) detect_sel_reg (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (wr_det),
    .data_i  (dat_i[`THRESH_MSB:`THRESH_LSB]),
    .value_o (detect_sel_q)
  );

  // power-down option; held until rewritten or reset
  supervisor_field_reg #(
    .WIDTH       (8),
    .RESET_VALUE (`POWER_DOWN_RST)
  ) pd_option_reg (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (wr_pd),
    .data_i  (dat_i[7:0]),
    .value_o (pd_option_q)
  );

  // a new event in the clearing cycle wins, so no detection is lost
  always @* begin
    flag_d = flag_q;
    if (det_evt) begin
      flag_d = 1'b1;
    end else if (flag_clr) begin
      flag_d = 1'b0;
    end
  end

  // sticky: only a software write of zero or a reset takes it down
  always @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // read data is captured with the ack and held until the next read
  always @* begin
    rdata_d = dat_o;
    if (rd_req) begin
      case (idx)
        `RESET_CTRL_IDX: begin
          rdata_d = {27'h0, flag_q, reset_sel_q};
        end
        `DETECT_CTRL_IDX: begin
          rdata_d = {28'h0, detect_sel_q};
        end
        // the option register is write-only and reads as zero
        `POWER_DOWN_IDX: begin
          rdata_d = 32'h0000_0000;
        end
        // unmapped slots are still acked and read as zero
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // cleared by reset so the first read never shows stale data
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else begin
      dat_o <= rdata_d;
    end
  end

  // only the two keys disable anything; a stray value leaves both resets on
  // decoded combinationally so a key takes hold one edge after its write
  always @* begin
    lowv_reset_off = 1'b0;
    power_on_off   = 1'b0;
    case (pd_option_q)
      `KEY_BOTH_OFF: begin
        lowv_reset_off = 1'b1;
        power_on_off   = 1'b1;
      end
      `KEY_RESET_OFF: begin
        lowv_reset_off = 1'b1;
      end
      default: begin
        lowv_reset_off = 1'b0;
        power_on_off   = 1'b0;
      end
    endcase
  end

  // levels toward the analog side; the thresholds themselves live there
  // the flag is a plain level: this block raises no interrupt of its own
  assign reset_threshold_select_o    = reset_sel_q;
  assign detect_threshold_select_o   = detect_sel_q;
  assign detect_enable_o             = det_en;
  assign detect_interrupt_flag_o     = flag_q;
  assign low_voltage_reset_disable_o = lowv_reset_off;
  assign power_on_reset_disable_o    = power_on_off;

endmodule // supply_supervisor_control

// loadable field register; reset value set per instance
module supervisor_field_reg #(
  parameter             WIDTH       = 4,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // load strobe and new value
  input  wire             load_i,
  input  wire [WIDTH-1:0] data_i,
  output reg  [WIDTH-1:0] value_o
);

  // the load strobe already excludes the ack cycle, so a held request writes once
  always @(posedge clk_i) begin
    if (rst_i) begin
      value_o <= RESET_VALUE;
    end else if (load_i) begin
      value_o <= data_i;
    end
  end

endmodule // supervisor_field_reg

// ### rtl/supply_supervisor_defines.vh
// register map, field positions and reset values of the supply supervisor block
`ifndef SUPPLY_SUPERVISOR_DEFINES_VH
`define SUPPLY_SUPERVISOR_DEFINES_VH

// register indices; the byte address is four times the index
`define RESET_CTRL_IDX      8'he3
`define DETECT_CTRL_IDX     8'he4
`define POWER_DOWN_IDX      8'he5

// fields
`define THRESH_MSB          3
`define THRESH_LSB          0
`define FLAG_BIT            4

// reset values and the detect-off code
`define THRESH_RST          4'h0
`define POWER_DOWN_RST      8'h00
`define DETECT_OFF_CODE     4'h0

// power-down option keys
`define KEY_BOTH_OFF        8'h37
`define KEY_RESET_OFF       8'h38

`endif

// ### tb/supply_supervisor_sva.sv
// assertions on the supervisor register ports
module supply_supervisor_sva (input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic supply_below_detect_i, detect_enable_o, detect_interrupt_flag_o,
  input wire logic low_voltage_reset_disable_o, power_on_reset_disable_o,
  input wire logic [9:0] adr_i, input wire logic [3:0] sel_i, reset_threshold_select_o,
  input wire logic [3:0] detect_threshold_select_o, input wire logic [31:0] dat_i);
  default clocking c @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // index of a write taken at this edge, zero when none is taken
  wire [7:0] x = {8{cyc_i & stb_i & we_i & ~ack_o & sel_i[0]}} & adr_i[9:2];
  wire [7:0] d = dat_i[7:0];
  wire s = detect_enable_o & supply_below_detect_i;
  wire lv = low_voltage_reset_disable_o;
  wire po = power_on_reset_disable_o;
  property p_rs; x == 8'he3 |=> reset_threshold_select_o == $past(d[3:0]); endproperty
  a_rs: assert property (p_rs) else $error("reset select");
  // a set in the same cycle wins, so only a quiet comparator demands the clear
  property p_cl; x == 8'he3 && !d[4] && !s |=> !detect_interrupt_flag_o; endproperty
  a_cl: assert property (p_cl) else $error("flag clear");
  property p_ds; x == 8'he4 |=> detect_enable_o == (|$past(d[3:0])) &&
    detect_threshold_select_o == $past(d[3:0]); endproperty
  a_ds: assert property (p_ds) else $error("detect enable");
  property p_bo; x == 8'he5 && d == 8'h37 |=> lv && po; endproperty
  a_bo: assert property (p_bo) else $error("both off");
  property p_ro; x == 8'he5 && d == 8'h38 |=> lv && !po; endproperty
  a_ro: assert property (p_ro) else $error("reset off");
  property p_st; s |=> detect_interrupt_flag_o; endproperty
  a_st: assert property (p_st) else $error("flag set");
  c_wo: cover property (x == 8'he5);
  c_st: cover property (s);
  c_cl: cover property (x == 8'he3 && detect_interrupt_flag_o);
endmodule // supply_supervisor_sva
bind supply_supervisor_control supply_supervisor_sva supply_supervisor_sva_inst (.*);

// ### tb/tb_supply_supervisor_control.sv
// bench for the supervisor registers
module tb_supply_supervisor_control;
  timeunit 1ns; timeprecision 100ps;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, bl = 0, ack_o, lv, po;
  logic [9:0]  adr_i = '0;
  logic [31:0] dat_i = '0, dat_o;
  logic [4:0]  q[$];
  int n_mismatch = 0, comparisons = 0;
  supply_supervisor_control supply_supervisor_control_inst (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .supply_below_detect_i(bl),
    .reset_threshold_select_o(), .detect_threshold_select_o(), .detect_enable_o(),
    .detect_interrupt_flag_o(), .low_voltage_reset_disable_o(lv), .power_on_reset_disable_o(po));
  initial forever #12.5 clk_i = ~clk_i;
  task chk(input logic [4:0] e, g);
    comparisons++;
    if (e !== g) begin n_mismatch++; $display("Error %0t: %h %h", $time, e, g); end
  endtask
  task chk_off(input logic [1:0] e);
    comparisons++;
    if (e !== {lv, po}) begin
      n_mismatch++;
      $display("Error %0t: %h %h", $time, e, {lv, po});
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] x, input logic [31:0] d, input logic [4:0] e);
    int n;
    n = 0;
    if (!w) q.push_back(e);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= {x, 2'h0}; dat_i <= d;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 9);
    if (ack_o !== 1'b1) begin n_mismatch++; give_verdict; end
    cyc_i <= 0; stb_i <= 0;
    @(posedge clk_i);
  endtask
  // read data is judged at the ack edge, while the request still stands
  always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0)
    chk(q.pop_front(), dat_o[4:0]);
  initial begin
    void'($urandom(32'hc032));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, 8'he5, 0, 0);
    for (int i = 0; i < 16; i++) begin
      wb(1, 8'he3, $urandom << 4 | i, 0);
      wb(0, 8'he3, 0, i);
      wb(1, 8'he4, i, 0);
      wb(0, 8'he4, 0, i);
    end
    wb(1, 8'he4, $urandom_range(15, 1), 0);
    bl <= 1;
    @(posedge clk_i);
    bl <= 0;
    wb(0, 8'he3, 0, 5'h1f);
    wb(1, 8'he3, 32'hef, 0);
    wb(0, 8'he3, 0, 5'h0f);
    wb(1, 8'he4, 0, 0);
    bl <= 1;
    @(posedge clk_i);
    bl <= 0;
    wb(0, 8'he3, 0, 5'h0f);
    wb(1, 8'he5, 32'h37, 0);
    chk_off(2'h3);
    wb(1, 8'he5, 32'h38, 0);
    chk_off(2'h2);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk_off(2'h0);
    wb(0, 8'he3, 0, 5'h00);
    wb(0, 8'he4, 0, 5'h00);
    give_verdict;
  end
endmodule // tb_supply_supervisor_control
